// *** core/wlt_defines.vh ***
// constants for the window and level trigger block
`ifndef WLT_DEFINES_VH
`define WLT_DEFINES_VH

// =====================================================
// register offsets (byte addresses)
`define WLT_OFF_CTRL     12'h000
`define WLT_OFF_WIN_UP   12'h004
`define WLT_OFF_WIN_LO   12'h008
`define WLT_OFF_WIN_HYS  12'h00c
`define WLT_OFF_WIN_DLY  12'h010
`define WLT_OFF_LVL_THR  12'h014
`define WLT_OFF_LVL_HYS  12'h018
`define WLT_OFF_STATUS   12'h01c
`define WLT_OFF_IRQ_ST   12'h020
`define WLT_OFF_IRQ_MSK  12'h024

// =====================================================
// control register fields
`define WLT_CTRL_WIN_POL  0
`define WLT_CTRL_LVL_POL  1
`define WLT_CTRL_COND_LSB 2
`define WLT_CTRL_COND_MSB 3
`define WLT_CTRL_RST      32'h0000_0003

// level condition encodings
`define WLT_COND_BELOW 2'h0
`define WLT_COND_ABOVE 2'h1
`define WLT_COND_BOTH  2'h2

// =====================================================
// reset values of thresholds
`define WLT_WIN_UP_RST 32'h0000_0001
`define WLT_ZERO32     32'h0000_0000

// interrupt status / mask bits
`define WLT_IRQ_WIN  0
`define WLT_IRQ_LVL  1
`define WLT_IRQ_BITS 2

// =====================================================
// timing: sample periods per millisecond at the default sample rate
`define WLT_SAMPLE_HZ 19200
`define WLT_MS_PER_S  1000

`endif

// *** core/wlt_delay_qual.v ***
// qualifying delay counter for the window trigger
`timescale 1ns/1ps
`include "wlt_defines.vh"

module wlt_delay_qual #(
  parameter CNT_W = 32
) (
  input wire pclk,
  input wire presetn,
  input wire sample_stb,
  input wire restart,
  input wire [CNT_W-1:0] limit,
  output reg done_reg
);

  reg [CNT_W-1:0] cnt_reg;
  wire [CNT_W-1:0] cnt_next;

  // saturate so a long candidate never wraps back below the limit
  assign cnt_next = (cnt_reg == {CNT_W{1'b1}}) ? cnt_reg : cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= {CNT_W{1'b0}};
      done_reg <= 1'b0;
    end else if (sample_stb) begin
      if (restart) begin
        cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
        done_reg <= (limit <= {{(CNT_W-1){1'b0}}, 1'b1});
      end else begin
        cnt_reg <= cnt_next;
        done_reg <= (cnt_next >= limit);
      end
    end
  end

endmodule

// *** core/wlt_top.v ***
// window and level trigger with apb register access
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "wlt_defines.vh"

module wlt_top #(
  parameter DATA_W = 32,
  parameter SAMPLES_PER_MS = `WLT_SAMPLE_HZ / `WLT_MS_PER_S
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sample_stb,
  input wire sample_valid,
  input wire [DATA_W-1:0] sample_data,
  output reg win_flag,
  output reg lvl_flag,
  output reg irq
);

  // =====================================================
  // apb registers
  reg [31:0] ctrl_reg;
  reg signed [31:0] win_up_reg;
  reg signed [31:0] win_lo_reg;
  reg signed [31:0] win_hys_reg;
  reg [31:0] win_dly_reg;
  reg signed [31:0] lvl_thr_reg;
  reg signed [31:0] lvl_hys_reg;
  reg [`WLT_IRQ_BITS-1:0] irq_st_reg;
  reg [`WLT_IRQ_BITS-1:0] irq_msk_reg;

  wire win_pol = ctrl_reg[`WLT_CTRL_WIN_POL];
  wire lvl_pol = ctrl_reg[`WLT_CTRL_LVL_POL];
  wire [1:0] cond = ctrl_reg[`WLT_CTRL_COND_MSB:`WLT_CTRL_COND_LSB];

  wire acc = psel & penable;
  wire wr = acc & pwrite;
  // unmapped offsets answer with pslverr and read as zero
  wire known = (paddr == `WLT_OFF_CTRL) || (paddr == `WLT_OFF_WIN_UP) || (paddr == `WLT_OFF_WIN_LO) ||
               (paddr == `WLT_OFF_WIN_HYS) || (paddr == `WLT_OFF_WIN_DLY) || (paddr == `WLT_OFF_LVL_THR) ||
               (paddr == `WLT_OFF_LVL_HYS) || (paddr == `WLT_OFF_STATUS) || (paddr == `WLT_OFF_IRQ_ST) ||
               (paddr == `WLT_OFF_IRQ_MSK);

  // =====================================================
  // sample input synchroniser (comes from the measurement chain clock-wise outside)
  reg stb_s1_reg;
  reg stb_s2_reg;
  reg stb_s3_reg;
  reg val_s1_reg;
  reg val_s2_reg;
  reg signed [31:0] dat_s1_reg;
  reg signed [31:0] dat_s2_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_s1_reg <= 1'b0;
      stb_s2_reg <= 1'b0;
      stb_s3_reg <= 1'b0;
      val_s1_reg <= 1'b0;
      val_s2_reg <= 1'b0;
      dat_s1_reg <= `WLT_ZERO32;
      dat_s2_reg <= `WLT_ZERO32;
    end else begin
      stb_s1_reg <= sample_stb;
      stb_s2_reg <= stb_s1_reg;
      stb_s3_reg <= stb_s2_reg;
      val_s1_reg <= sample_valid;
      val_s2_reg <= val_s1_reg;
      dat_s1_reg <= $signed(sample_data[31:0]);
      dat_s2_reg <= dat_s1_reg;
    end
  end

  // the word is not gray coded: the far side must settle it a clock ahead of the strobe
  // one evaluation per rising edge of the sample strobe
  wire upd = stb_s2_reg & ~stb_s3_reg;
  wire signed [31:0] x = dat_s2_reg;
  wire x_ok = val_s2_reg;

  // =====================================================
  // window trigger
  // 33-bit sums avoid overflow when thresholds sit near full scale
  wire signed [32:0] up_hys = {win_up_reg[31], win_up_reg} + {win_hys_reg[31], win_hys_reg};
  wire signed [32:0] lo_hys = {win_lo_reg[31], win_lo_reg} - {win_hys_reg[31], win_hys_reg};
  wire signed [32:0] xe = {x[31], x};
  wire in_core = (x >= win_lo_reg) && (x <= win_up_reg);
  wire in_wide = (xe >= lo_hys) && (xe <= up_hys);

  reg win_in_reg;
  reg win_cand_reg;
  // an overlong delay saturates rather than wrapping to a short one
  wire [63:0] dly_prod = win_dly_reg * SAMPLES_PER_MS;
  wire [31:0] dly_lim = (dly_prod[63:32] != 32'h0000_0000) ? 32'hffff_ffff : dly_prod[31:0];
  wire dly_done;

  // the delay counts from the last threshold crossing, so leaving through the
  // hysteresis band later is not held back a second time
  wire cand_now = in_core;
  wire restart = (cand_now != win_cand_reg);

  wlt_delay_qual #(
    .CNT_W(32)
  ) u_dly (
    .pclk(pclk),
    .presetn(presetn),
    .sample_stb(upd),
    .restart(restart),
    .limit(dly_lim),
    .done_reg(dly_done)
  );

  reg win_in_next;
  always @* begin
    win_in_next = win_in_reg;
    if (!x_ok) begin
      win_in_next = 1'b0;
    end else if (!win_in_reg) begin
      // entry across a threshold waits for the delay
      if (in_core && (win_dly_reg == `WLT_ZERO32 || (!restart && dly_done))) begin
        win_in_next = 1'b1;
      end
    end else if (!in_wide) begin
      // leaving past the hysteresis band, delay only counts the crossing
      if (win_dly_reg == `WLT_ZERO32 || (!restart && dly_done)) begin
        win_in_next = 1'b0;
      end
    end
  end

  // =====================================================
  // level trigger
  wire signed [32:0] thr_e = {lvl_thr_reg[31], lvl_thr_reg};
  wire signed [32:0] hys_e = {lvl_hys_reg[31], lvl_hys_reg};
  wire above = x > lvl_thr_reg;
  wire below = x < lvl_thr_reg;
  // arm: the input came back by the hysteresis amount since the last event
  // fresh: validity returned and no event has happened since
  reg lvl_act_reg;
  reg lvl_arm_reg;
  reg lvl_fresh_reg;
  reg lvl_dir_reg;
  reg lvl_act_next;
  reg lvl_arm_next;
  reg lvl_fresh_next;
  reg lvl_dir_next;

  always @* begin
    lvl_act_next = lvl_act_reg;
    lvl_arm_next = lvl_arm_reg;
    lvl_fresh_next = lvl_fresh_reg;
    lvl_dir_next = lvl_dir_reg;
    if (!x_ok) begin
      lvl_act_next = 1'b0;
      lvl_arm_next = 1'b1;
      lvl_fresh_next = 1'b1;
    end else begin
      if (lvl_act_reg) begin
        // release requires return across the threshold by the hysteresis amount
        if (lvl_dir_reg ? (xe <= thr_e - hys_e) : (xe >= thr_e + hys_e)) begin
          lvl_act_next = 1'b0;
          lvl_arm_next = 1'b1;
        end else if (lvl_fresh_reg && (lvl_dir_reg ? !above : !below)) begin
          lvl_act_next = 1'b0;
        end
      end
      // a release and a crossing the other way may fall in one sample
      if (!lvl_act_next && (lvl_arm_next || lvl_fresh_next)) begin
        if (above && (cond != `WLT_COND_BELOW)) begin
          lvl_act_next = 1'b1;
          lvl_dir_next = 1'b1;
          lvl_arm_next = 1'b0;
          lvl_fresh_next = 1'b0;
        end else if (below && (cond != `WLT_COND_ABOVE)) begin
          lvl_act_next = 1'b1;
          lvl_dir_next = 1'b0;
          lvl_arm_next = 1'b0;
          lvl_fresh_next = 1'b0;
        end
      end
    end
  end

  // =====================================================
  // state updated only on a sample; flags also follow a polarity change between samples
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_in_reg <= 1'b0;
      win_cand_reg <= 1'b0;
      lvl_act_reg <= 1'b0;
      lvl_arm_reg <= 1'b1;
      lvl_fresh_reg <= 1'b1;
      lvl_dir_reg <= 1'b0;
      win_flag <= 1'b0;
      lvl_flag <= 1'b0;
    end else if (upd) begin
      win_in_reg <= win_in_next;
      win_cand_reg <= x_ok ? cand_now : 1'b0;
      lvl_act_reg <= lvl_act_next;
      lvl_arm_reg <= lvl_arm_next;
      lvl_fresh_reg <= lvl_fresh_next;
      lvl_dir_reg <= lvl_dir_next;
      win_flag <= win_in_next ? win_pol : ~win_pol;
      lvl_flag <= lvl_act_next ? lvl_pol : ~lvl_pol;
    end else begin
      // polarity change shows at once, not at the next sample
      win_flag <= win_in_reg ? win_pol : ~win_pol;
      lvl_flag <= lvl_act_reg ? lvl_pol : ~lvl_pol;
    end
  end

  // =====================================================
  // interrupt events: a change of trigger state
  wire [`WLT_IRQ_BITS-1:0] ev;
  assign ev[`WLT_IRQ_WIN] = upd & (win_in_next != win_in_reg);
  assign ev[`WLT_IRQ_LVL] = upd & (lvl_act_next != lvl_act_reg);
  wire [`WLT_IRQ_BITS-1:0] w1c = (wr && paddr == `WLT_OFF_IRQ_ST) ? pwdata[`WLT_IRQ_BITS-1:0] : 2'h0;
  // the output follows a mask write in the same cycle, not one later
  wire [`WLT_IRQ_BITS-1:0] msk_next = (wr && paddr == `WLT_OFF_IRQ_MSK) ? pwdata[`WLT_IRQ_BITS-1:0] : irq_msk_reg;
  // set wins over a same-cycle clear
  wire [`WLT_IRQ_BITS-1:0] st_next = (irq_st_reg & ~w1c) | ev;

  // =====================================================
  // register writes; limits are stored as given, never checked
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `WLT_CTRL_RST;
      win_up_reg <= `WLT_WIN_UP_RST;
      win_lo_reg <= `WLT_ZERO32;
      win_hys_reg <= `WLT_ZERO32;
      win_dly_reg <= `WLT_ZERO32;
      lvl_thr_reg <= `WLT_ZERO32;
      lvl_hys_reg <= `WLT_ZERO32;
      irq_st_reg <= 2'h0;
      irq_msk_reg <= 2'h0;
      irq <= 1'b0;
    end else begin
      if (wr) begin
        case (paddr)
          `WLT_OFF_CTRL: ctrl_reg <= pwdata;
          `WLT_OFF_WIN_UP: win_up_reg <= pwdata;
          `WLT_OFF_WIN_LO: win_lo_reg <= pwdata;
          `WLT_OFF_WIN_HYS: win_hys_reg <= pwdata;
          `WLT_OFF_WIN_DLY: win_dly_reg <= pwdata;
          `WLT_OFF_LVL_THR: lvl_thr_reg <= pwdata;
          `WLT_OFF_LVL_HYS: lvl_hys_reg <= pwdata;
          `WLT_OFF_IRQ_MSK: irq_msk_reg <= pwdata[`WLT_IRQ_BITS-1:0];
          default: ;
        endcase
      end
      irq_st_reg <= st_next;
      irq <= |(st_next & msk_next);
    end
  end

  // =====================================================
  // apb read and answer, zero wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `WLT_ZERO32;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
      prdata <= `WLT_ZERO32;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `WLT_OFF_CTRL: prdata <= ctrl_reg;
          `WLT_OFF_WIN_UP: prdata <= win_up_reg;
          `WLT_OFF_WIN_LO: prdata <= win_lo_reg;
          `WLT_OFF_WIN_HYS: prdata <= win_hys_reg;
          `WLT_OFF_WIN_DLY: prdata <= win_dly_reg;
          `WLT_OFF_LVL_THR: prdata <= lvl_thr_reg;
          `WLT_OFF_LVL_HYS: prdata <= lvl_hys_reg;
          `WLT_OFF_STATUS: prdata <= {28'h0000000, x_ok, lvl_act_reg, win_in_reg, win_cand_reg};
          `WLT_OFF_IRQ_ST: prdata <= {30'h0, irq_st_reg};
          `WLT_OFF_IRQ_MSK: prdata <= {30'h0, irq_msk_reg};
          default: prdata <= `WLT_ZERO32;
        endcase
      end
    end
  end

endmodule

// *** test/wlt_props.sv ***
// port assertions for the window and level trigger
`timescale 1ns/1ps
module wlt_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire sample_stb,
  input wire sample_valid,
  input wire win_flag,
  input wire lvl_flag,
  input wire irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====================================
  // helpers
  reg pol_w_reg;
  reg pol_l_reg;
  reg stb_q_reg;
  reg [3:0] quiet_reg;
  wire wr_ctrl = psel && penable && pready && pwrite && paddr == 12'h000;
  // polarity is snooped from control writes, as the ports alone hide it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_w_reg <= 1'b1;
      pol_l_reg <= 1'b1;
      stb_q_reg <= 1'b0;
      quiet_reg <= 4'hf;
    end else begin
      stb_q_reg <= sample_stb;
      if (wr_ctrl) begin
        pol_w_reg <= pwdata[0];
        pol_l_reg <= pwdata[1];
      end
      if ((sample_stb && !stb_q_reg) || (psel && pwrite))
        quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hf)
        quiet_reg <= quiet_reg + 4'h1;
    end
  end
  sequence bad_upd_s;
    $past(sample_stb, 2) && !$past(sample_stb, 3) && !$past(sample_valid, 2);
  endsequence
  // =====================================
  // assertions
  ready_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  invalid_win_a: assert property (bad_upd_s |-> ##2 win_flag == !pol_w_reg)
    else $error("window flag active on invalid sample");
  invalid_lvl_a: assert property (bad_upd_s |-> ##2 lvl_flag == !pol_l_reg)
    else $error("level flag active on invalid sample");
  win_pol_a: assert property (wr_ctrl && pwdata[0] != pol_w_reg |=> ##2 win_flag != $past(win_flag, 3))
    else $error("window flag ignored polarity change");
  lvl_pol_a: assert property (wr_ctrl && pwdata[1] != pol_l_reg |=> ##2 lvl_flag != $past(lvl_flag, 3))
    else $error("level flag ignored polarity change");
  flag_cause_a: assert property ($changed(win_flag) || $changed(lvl_flag) |-> quiet_reg < 4'h6)
    else $error("flag moved without sample or write");
  irq_clear_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("irq dropped without a write");
  cover property ($rose(irq));
  cover property (pslverr);
  cover property ($rose(lvl_flag));
endmodule

// *** test/wlt_sample_src.sv ***
// upstream channel model handing samples to the trigger
`timescale 1ns/1ps
module wlt_sample_src (
  input wire pclk,
  output reg sample_stb,
  output reg sample_valid,
  output reg [31:0] sample_data
);
  initial begin
    sample_stb = 1'b0;
    sample_valid = 1'b1;
    sample_data = 32'h0000_0000;
  end
  // one update per call; data scrambled once its hold has run out
  task send(input [31:0] d, input v);
    begin
      // word and validity settle a clock ahead of the strobe edge
      @(posedge pclk);
      sample_data <= d;
      sample_valid <= v;
      @(posedge pclk);
      sample_stb <= 1'b1;
      repeat (3) @(posedge pclk);
      sample_stb <= 1'b0;
      repeat (6) @(posedge pclk);
      sample_data <= ~d;
    end
  endtask
endmodule

// *** test/wlt_tb_top.sv ***
// self-checking bench for the window and level trigger
`timescale 1ns/1ps
module wlt_tb_top;
  reg pclk;
  reg presetn;
  reg psel;
  reg penable;
  reg pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire sample_stb;
  wire sample_valid;
  wire [31:0] sample_data;
  wire win_flag;
  wire lvl_flag;
  wire irq;
  integer n_mismatch = 0;
  integer checks = 0;
  integer cyc = 0;
  integer c;
  integer sg;
  reg [31:0] r;
  reg e;
  // short delay unit keeps the qualifying test brief
  wlt_top #(.SAMPLES_PER_MS(2)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sample_stb, .sample_valid, .sample_data, .win_flag, .lvl_flag, .irq);
  wlt_sample_src u_src (.pclk, .sample_stb, .sample_valid, .sample_data);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // =====================================
  // shared tasks
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // only the bench timeout ends this wait
      while (pready !== 1'b1)
        @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdc(input [11:0] a, input [31:0] exp, input ee);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(r, exp);
      chk(e, ee);
    end
  endtask
  task sw(input [31:0] d, input v, input ew);
    begin
      u_src.send(d, v);
      chk(win_flag, ew);
    end
  endtask
  task sl(input [31:0] d, input v, input el);
    begin
      u_src.send(d, v);
      chk(lvl_flag, el);
    end
  endtask
  task summarize;
    begin
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // =====================================
  // scenarios
  task t_window;
    begin
      rdc(12'h000, 32'h0000_0003, 1'b0);
      rdc(12'h0fc, 32'h0000_0000, 1'b1);
      apb(1'b1, 12'h004, 32'd100);
      apb(1'b1, 12'h008, 32'd10);
      apb(1'b1, 12'h00c, 32'd5);
      sw(32'd50, 1'b1, 1'b1);
      sw(32'd103, 1'b1, 1'b1);
      sw(32'd106, 1'b1, 1'b0);
      sw(32'd103, 1'b1, 1'b0);
      sw(32'd50, 1'b1, 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0002);
      repeat (3) @(posedge pclk);
      chk(win_flag, 1'b0);
      sw(32'd200, 1'b1, 1'b1);
      sw(32'd50, 1'b0, 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0003);
      sw(32'd50, 1'b0, 1'b0);
      $display("test window done");
    end
  endtask
  task t_delay;
    begin
      apb(1'b1, 12'h010, 32'd1);
      sw(32'd50, 1'b1, 1'b0);
      sw(32'd200, 1'b1, 1'b0);
      sw(32'd50, 1'b1, 1'b0);
      sw(32'd50, 1'b1, 1'b0);
      sw(32'd50, 1'b1, 1'b1);
      sw(32'd200, 1'b1, 1'b1);
      sw(32'd103, 1'b1, 1'b1);
      sw(32'd106, 1'b1, 1'b0);
      apb(1'b1, 12'h010, 32'd0);
      $display("test delay done");
    end
  endtask
  task t_level;
    begin
      apb(1'b1, 12'h018, 32'd10);
      for (c = 1; c >= 0; c = c - 1) begin
        sg = c ? 1 : -1;
        apb(1'b1, 12'h000, 32'h3 | (c << 2));
        sl(sg * 20, 1'b1, 1'b1);
        sl(sg * -5, 1'b1, 1'b1);
        sl(sg * -20, 1'b1, 1'b0);
        sl(sg * 20, 1'b1, 1'b1);
        apb(1'b1, 12'h000, 32'h1 | (c << 2));
        repeat (3) @(posedge pclk);
        chk(lvl_flag, 1'b0);
        apb(1'b1, 12'h000, 32'h3 | (c << 2));
        sl(sg * 20, 1'b0, 1'b0);
        sl(sg * 20, 1'b1, 1'b1);
      end
      apb(1'b1, 12'h000, 32'h0000_000b);
      sl(32'd20, 1'b1, 1'b1);
      sl(32'hffff_ffec, 1'b1, 1'b1);
      sl(32'd20, 1'b0, 1'b0);
      $display("test level done");
    end
  endtask
  task t_irq;
    begin
      apb(1'b1, 12'h000, 32'h0000_0003);
      apb(1'b1, 12'h020, 32'h0000_0003);
      apb(1'b1, 12'h024, 32'h0000_0001);
      sw(32'd200, 1'b1, 1'b0);
      sw(32'd50, 1'b1, 1'b1);
      chk(irq, 1'b1);
      apb(1'b1, 12'h020, 32'h0000_0001);
      @(posedge pclk);
      chk(irq, 1'b0);
      apb(1'b1, 12'h024, 32'h0000_0000);
      sw(32'd200, 1'b1, 1'b0);
      chk(irq, 1'b0);
      rdc(12'h020, 32'h0000_0001, 1'b0);
      $display("test irq done");
    end
  endtask
  // =====================================
  // main sequence and hang guard
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      summarize;
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_window;
    t_delay;
    t_level;
    t_irq;
    summarize;
  end
endmodule
bind wlt_top wlt_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .sample_stb, .sample_valid, .win_flag, .lvl_flag, .irq);
